// ===== pkg/ldm_pkg.sv
package ldm_pkg;
    // Mode strap decode: ground, open, supply
    typedef enum logic [1:0] {
        ldm_mode_direct_pwm,
        ldm_mode_serial,
        ldm_mode_dc_interface
    } ldm_mode_t;

    // Three-state strap levels as seen at the strap sense pins
    localparam logic [1:0] STRAP_GROUND = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_SUPPLY = 2'h2;

    localparam int DUTY_WIDTH = 8;
    localparam int FRAME_BYTES = 4;
    localparam int FRAME_BITS = FRAME_BYTES * DUTY_WIDTH;
    localparam int GROUP_COUNT = 4;
    localparam int PWM_PERIOD_CYCLES = 256;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_MIN_ON = 8'h02;

    // Host-side timing figures (kept for reference by the bench)
    localparam int MIN_HIGH_TIME_US = 8;
    localparam int MAX_PWM_FREQ_HZ = 488;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MIN_HIGH_CYCLES = (MIN_HIGH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Group order inside a frame and on the duty bus
    localparam int GROUP_A = 0;
    localparam int GROUP_B = 1;
    localparam int GROUP_C = 2;
    localparam int GROUP_D = 3;
endpackage : ldm_pkg

// ===== hw/ldm_pwm_counter.sv
`timescale 1ns/1ns
// Free-running PWM period counter shared by all groups
module ldm_pwm_counter #(
    parameter int PERIOD = ldm_pkg::PWM_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    output logic [$clog2(PERIOD)-1:0] phase,
    output logic period_start
);
    // Wrap at the period end
    always_ff @(posedge clk)
    begin
        if (reset)
            phase <= '0;
        else if (phase == ($clog2(PERIOD))'(PERIOD - 1))
            phase <= '0;
        else
            phase <= phase + 1'b1;
    end

    assign period_start = (phase == '0);
endmodule : ldm_pwm_counter

// ===== hw/ldm_controller.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - Strap picks direct, serial or DC mode
// RULE_02 - Channels 0-1 and 2-3 share duties
// RULE_03 - Channels 4 and 5 dimmed independently
// RULE_04 - Undriven dimming inputs read as low
// RULE_05 - Direct mode: input high means channel on
// RULE_06 - Host holds inputs high at least 8 us
// RULE_07 - Host keeps PWM at most 488 Hz
// RULE_08 - Serial mode: group A input is data
// RULE_09 - Serial mode: group B input shifts bits
// RULE_10 - Serial mode: ch4 input is frame strobe
// RULE_11 - Serial mode ignores ch5 input
// RULE_12 - Frame is four eight-bit duty bytes
// RULE_13 - Byte zero off, all ones full on
// RULE_14 - Bytes map to groups A, B, C, D
// RULE_15 - Data captured on shift clock rising edge
// RULE_16 - Strobe falling edge loads buffered bytes
// RULE_17 - On-time (v+1)/256, values 1,2 give 2/256
// RULE_18 - Serial PWM period is 256 clocks
// RULE_19 - Bits arrive MSB first, bytes in order
// RULE_20 - Old duties hold until frame strobe
module ldm_controller (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode_strap,
    input wire logic group_a_dim_input,
    input wire logic group_b_dim_input,
    input wire logic ch4_dim_input,
    input wire logic ch5_dim_input,
    input wire logic out_ready,
    output logic system_clock_output,
    output logic led_channel_zero,
    output logic led_channel_one,
    output logic led_channel_two,
    output logic led_channel_three,
    output logic led_channel_four,
    output logic led_channel_five,
    output logic [1:0] active_mode,
    output logic frame_valid,
    output logic [31:0] frame_data,
    output logic frame_overrun
);
    localparam int W = ldm_pkg::DUTY_WIDTH;
    localparam int NB = ldm_pkg::FRAME_BITS;

    // Two-flop synchronisers for the strap and dimming pins (not out_ready); pull-downs make floating pins low
    logic [5:0] sync_meta;
    logic [5:0] sync_pin;
    logic [5:0] sync_prev;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_meta <= 6'h00; // RULE_04
            sync_pin <= 6'h00;
            sync_prev <= 6'h00;
        end
        else
        begin
            sync_meta <= {mode_strap, ch5_dim_input, ch4_dim_input, group_b_dim_input, group_a_dim_input};
            sync_pin <= sync_meta;
            sync_prev <= sync_pin;
        end
    end

    logic dat_s;
    logic sck_s;
    logic eof_s;
    logic ch5_s;
    logic [1:0] strap_s;
    assign dat_s = sync_pin[0];
    assign sck_s = sync_pin[1];
    assign eof_s = sync_pin[2];
    assign ch5_s = sync_pin[3];
    assign strap_s = sync_pin[5:4];

    // Strap decode; an illegal code falls back to direct mode
    function automatic ldm_pkg::ldm_mode_t decode_strap(input logic [1:0] s);
        ldm_pkg::ldm_mode_t m;
        m = ldm_pkg::ldm_mode_direct_pwm;
        if (s == ldm_pkg::STRAP_OPEN)
            m = ldm_pkg::ldm_mode_serial;
        else if (s == ldm_pkg::STRAP_SUPPLY)
            m = ldm_pkg::ldm_mode_dc_interface;
        return m;
    endfunction : decode_strap

    // Strap trusted only once the sync pipeline holds real pin samples
    logic [1:0] settle;
    always_ff @(posedge clk)
    begin
        if (reset)
            settle <= 2'h0;
        else if (settle != 2'h3)
            settle <= settle + 2'h1;
    end

    // Mode is caught once after reset release; straps do not move in service
    ldm_pkg::ldm_mode_t mode;
    logic mode_taken;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode <= ldm_pkg::ldm_mode_direct_pwm;
            mode_taken <= 1'b0;
        end
        else if (!mode_taken && settle == 2'h3 && sync_prev[5:4] == strap_s)
        begin
            mode <= decode_strap(strap_s); // RULE_01
            mode_taken <= 1'b1;
        end
    end
    assign active_mode = mode;

    logic serial_mode;
    assign serial_mode = mode_taken && mode == ldm_pkg::ldm_mode_serial;

    // Edge detection on the synchronised link pins
    logic sck_rise;
    logic eof_fall;
    assign sck_rise = serial_mode && sck_s && !sync_prev[1]; // RULE_15 RULE_09
    assign eof_fall = serial_mode && !eof_s && sync_prev[2]; // RULE_16 RULE_10

    // Frame shift register, MSB first; first byte ends in the top lane
    logic [NB-1:0] shift;
    logic [5:0] bit_count;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            shift <= '0;
            bit_count <= 6'h00;
        end
        else if (eof_fall)
            bit_count <= 6'h00;
        else if (sck_rise)
        begin
            shift <= {shift[NB-2:0], dat_s}; // RULE_08 RULE_19
            if (bit_count != 6'(NB))
                bit_count <= bit_count + 6'h01;
        end
    end

    // Two-entry buffer between frame receiver and duty registers
    logic [NB-1:0] fifo_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] fifo_count;
    logic fifo_in_ready;
    logic fifo_push;
    logic fifo_pop;
    logic apply_ready;
    assign fifo_in_ready = fifo_count != 2'h2;
    // A frame needs all 32 bits before the strobe; short frames are dropped
    assign fifo_push = eof_fall && bit_count == 6'(NB) && fifo_in_ready; // RULE_12
    assign fifo_pop = fifo_count != 2'h0 && apply_ready;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fifo_count <= 2'h0;
        end
        else
        begin
            if (fifo_push)
                wr_ptr <= ~wr_ptr;
            if (fifo_pop)
                rd_ptr <= ~rd_ptr;
            fifo_count <= fifo_count + 2'(fifo_push) - 2'(fifo_pop);
        end
    end

    always_ff @(posedge clk)
    begin
        if (fifo_push)
            fifo_mem[wr_ptr] <= shift;
    end

    // Overrun is sticky: a strobe while the buffer is full loses that frame
    always_ff @(posedge clk)
    begin
        if (reset)
            frame_overrun <= 1'b0;
        else if (eof_fall && bit_count == 6'(NB) && !fifo_in_ready)
            frame_overrun <= 1'b1;
    end

    // Duties change only at a period boundary, avoiding runt pulses
    logic [7:0] phase;
    logic period_start;
    ldm_pwm_counter #(
        .PERIOD(ldm_pkg::PWM_PERIOD_CYCLES)
    ) u_counter (
        .clk(clk),
        .reset(reset),
        .phase(phase),
        .period_start(period_start)
    );
    assign apply_ready = period_start && out_ready;

    // Latest applied frame mirrored out for observation
    assign frame_valid = fifo_count != 2'h0;
    always_ff @(posedge clk)
    begin
        if (reset)
            frame_data <= 32'h00000000;
        else if (fifo_pop)
            frame_data <= fifo_mem[rd_ptr];
    end

    // Duty registers held until a whole new frame is applied
    logic [W-1:0] duty [ldm_pkg::GROUP_COUNT];
    genvar g;
    generate
        for (g = 0; g < ldm_pkg::GROUP_COUNT; g++)
        begin : g_duty
            always_ff @(posedge clk)
            begin
                if (reset)
                    duty[g] <= ldm_pkg::DUTY_RESET;
                else if (fifo_pop)
                    duty[g] <= fifo_mem[rd_ptr][NB-1-g*W -: W]; // RULE_14 RULE_20
            end
        end
    endgenerate

    // Compare threshold: v+1 counts, codes 1 and 2 both give 2
    function automatic logic [8:0] on_count(input logic [7:0] v);
        logic [8:0] c;
        c = 9'h000; // RULE_13
        if (v != 8'h00)
            c = (v <= ldm_pkg::DUTY_MIN_ON) ? 9'h002 : {1'b0, v} + 9'h001; // RULE_17
        return c;
    endfunction : on_count

    logic [3:0] serial_on;
    logic [3:0] direct_on;
    logic [3:0] group_on;
    generate
        for (g = 0; g < ldm_pkg::GROUP_COUNT; g++)
        begin : g_pwm
            assign serial_on[g] = {1'b0, phase} < on_count(duty[g]); // RULE_18
        end
    endgenerate

    // Direct mode passes the synchronised pins; ch5 is unused in serial mode
    assign direct_on = {ch5_s, eof_s, sck_s, dat_s}; // RULE_05 RULE_11

    // DC interface needs an analog front end; channels stay off here
    always_comb
    begin
        group_on = 4'h0;
        if (mode_taken)
        begin
            unique case (mode)
                ldm_pkg::ldm_mode_direct_pwm: group_on = direct_on;
                ldm_pkg::ldm_mode_serial: group_on = serial_on;
                ldm_pkg::ldm_mode_dc_interface: group_on = 4'h0;
                default: group_on = 4'h0;
            endcase
        end
    end

    // Registered channel drives and the clock output at half the clock rate
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            led_channel_zero <= 1'b0;
            led_channel_one <= 1'b0;
            led_channel_two <= 1'b0;
            led_channel_three <= 1'b0;
            led_channel_four <= 1'b0;
            led_channel_five <= 1'b0;
            system_clock_output <= 1'b0;
        end
        else
        begin
            led_channel_zero <= group_on[ldm_pkg::GROUP_A]; // RULE_02
            led_channel_one <= group_on[ldm_pkg::GROUP_A];
            led_channel_two <= group_on[ldm_pkg::GROUP_B];
            led_channel_three <= group_on[ldm_pkg::GROUP_B];
            led_channel_four <= group_on[ldm_pkg::GROUP_C]; // RULE_03
            led_channel_five <= group_on[ldm_pkg::GROUP_D];
            system_clock_output <= ~system_clock_output;
        end
    end
endmodule : ldm_controller

// ===== bench/ldm_checker.sv
`timescale 1ns/1ns
// Port checks on the dimming controller
module ldm_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic group_a_dim_input,
    input wire logic system_clock_output,
    input wire logic led_channel_zero,
    input wire logic led_channel_one,
    input wire logic led_channel_two,
    input wire logic led_channel_five,
    input wire logic [1:0] active_mode,
    input wire logic frame_valid,
    input wire logic [31:0] frame_data,
    input wire logic frame_overrun
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [3:0] up;
    // Settle count, hides mode latch and sync delay
    always_ff @(posedge clk)
        if (reset)
            up <= 4'h0;
        else if (up != 4'hf)
            up <= up + 4'h1;
    // Byte held long enough to reach the channel
    sequence s_byte_a(v);
        (active_mode == 2'h1 && up == 4'hf && frame_data[31:24] == v) [*3];
    endsequence
    AST_RESET: assert property (disable iff (1'b0) reset |=>
        !led_channel_zero && active_mode == 2'h0 && !frame_valid && !frame_overrun)
        else $error("reset did not clear");
    AST_PAIR_A: assert property (led_channel_zero == led_channel_one)
        else $error("pair split");
    AST_DIRECT: assert property (up == 4'hf && active_mode == 2'h0 |->
        led_channel_zero == $past(group_a_dim_input, 3))
        else $error("direct path wrong");
    AST_DC_OFF: assert property (active_mode == 2'h2 |->
        !led_channel_zero && !led_channel_two && !led_channel_five)
        else $error("dc mode not off");
    AST_SYSTEM_CLOCK_OUTPUT: assert property (up == 4'hf |->
        system_clock_output != $past(system_clock_output))
        else $error("clock out stuck");
    AST_HOLD: assert property (up == 4'hf && frame_data != $past(frame_data) |->
        $past(frame_valid))
        else $error("duty changed unasked");
    AST_ZERO: assert property (s_byte_a(8'h00) |-> !led_channel_zero)
        else $error("zero duty on");
    AST_FULL: assert property (s_byte_a(8'hff) |-> led_channel_zero)
        else $error("full duty off");
endmodule : ldm_checker

bind ldm_controller ldm_checker u_checker (
    .clk(clk),
    .reset(reset),
    .group_a_dim_input(group_a_dim_input),
    .system_clock_output(system_clock_output),
    .led_channel_zero(led_channel_zero),
    .led_channel_one(led_channel_one),
    .led_channel_two(led_channel_two),
    .led_channel_five(led_channel_five),
    .active_mode(active_mode),
    .frame_valid(frame_valid),
    .frame_data(frame_data),
    .frame_overrun(frame_overrun)
);

// ===== bench/ldm_host_model.sv
`timescale 1ns/1ns
// Serial frame sender; released lines sit at pull-down level
module ldm_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [31:0] word,
    input wire logic [5:0] bits,
    output logic sdata,
    output logic sclk,
    output logic strobe,
    output logic busy
);
    int i;
    // Shift clock offset from clk to avoid a locked phase
    initial
    begin
        {sdata, sclk, strobe, busy} = 4'h0;
        forever
        begin
            @(posedge clk iff go);
            busy <= 1'b1;
            strobe <= 1'b1;
            for (i = bits - 1; i >= 0; i--)
            begin
                sdata <= word[i];
                repeat (4) @(posedge clk);
                sclk <= #37 1'b1;
                repeat (4) @(posedge clk);
                sclk <= #37 1'b0;
            end
            sdata <= 1'b0;
            repeat (4) @(posedge clk);
            strobe <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule : ldm_host_model

// ===== bench/ldm_controller_tb_top.sv
`timescale 1ns/1ns
module ldm_controller_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] mode_strap = 2'h0;
    logic out_ready = 1'b1;
    logic ser = 1'b0;
    logic go = 1'b0;
    logic [3:0] pin = 4'h0;
    logic [31:0] word = 32'h0;
    logic [5:0] bits = 6'h20;
    logic sdata, sclk, strobe, busy, system_clock_output, frame_valid, frame_overrun;
    logic led_channel_zero, led_channel_one, led_channel_two, led_channel_three;
    logic led_channel_four, led_channel_five;
    logic [1:0] active_mode;
    logic [31:0] frame_data;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    wire group_a_dim_input = ser ? sdata : pin[0];
    wire group_b_dim_input = ser ? sclk : pin[1];
    wire ch4_dim_input = ser ? strobe : pin[2];
    wire ch5_dim_input = pin[3];
    wire [5:0] led = {led_channel_five, led_channel_four, led_channel_three,
        led_channel_two, led_channel_one, led_channel_zero};

    ldm_controller dut (
        .clk(clk),
        .reset(reset),
        .mode_strap(mode_strap),
        .group_a_dim_input(group_a_dim_input),
        .group_b_dim_input(group_b_dim_input),
        .ch4_dim_input(ch4_dim_input),
        .ch5_dim_input(ch5_dim_input),
        .out_ready(out_ready),
        .system_clock_output(system_clock_output),
        .led_channel_zero(led_channel_zero),
        .led_channel_one(led_channel_one),
        .led_channel_two(led_channel_two),
        .led_channel_three(led_channel_three),
        .led_channel_four(led_channel_four),
        .led_channel_five(led_channel_five),
        .active_mode(active_mode),
        .frame_valid(frame_valid),
        .frame_data(frame_data),
        .frame_overrun(frame_overrun)
    );
    ldm_host_model host (
        .clk(clk),
        .go(go),
        .word(word),
        .bits(bits),
        .sdata(sdata),
        .sclk(sclk),
        .strobe(strobe),
        .busy(busy)
    );

    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask : chk

    task automatic start(input logic [1:0] s);
        reset <= 1'b1;
        mode_strap <= s;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : start

    // One frame, then time for the next period start
    task automatic send(input logic [31:0] w, input logic [5:0] n);
        word <= w;
        bits <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (300) @(posedge clk);
    endtask : send

    task automatic duty(input int ch, input int exp);
        int n;
        n = 0;
        repeat (256)
        begin
            @(posedge clk);
            n += led[ch];
        end
        chk(n, exp);
    endtask : duty

    initial
    begin
        start(2'h0);
        chk(active_mode, 2'h0);
        for (int p = 0; p < 16; p++)
        begin
            // Static levels held 8 us each, never a fast 256-step dimming
            pin <= p[3:0];
            repeat (80) @(posedge clk);
            chk(led, {p[3], p[2], p[1], p[1], p[0], p[0]});
        end
        pin <= 4'hf;
        start(2'h2);
        chk({active_mode, led}, {2'h2, 6'h00});
        ser <= 1'b1;
        pin <= 4'h0;
        start(2'h1);
        chk(active_mode, 2'h1);
        send(32'h00ff0102, 6'h20);
        chk(frame_data, 32'h00ff0102);
        duty(0, 0);
        duty(2, 256);
        duty(4, 2);
        duty(5, 2);
        send(32'h807f03fe, 6'h1f);
        chk(frame_data, 32'h00ff0102);
        send(32'h807f03fe, 6'h20);
        duty(0, 129);
        duty(2, 128);
        duty(4, 4);
        duty(5, 255);
        out_ready <= 1'b0;
        send(32'hff223344, 6'h20);
        send(32'h55667788, 6'h20);
        send(32'haabbccdd, 6'h20);
        chk({frame_valid, frame_overrun, frame_data[7:0]}, 10'h3fe);
        out_ready <= 1'b1;
        repeat (600) @(posedge clk);
        chk({frame_valid, frame_overrun}, 2'h1);
        chk(frame_data, 32'h55667788);
        start(2'h3);
        chk(active_mode, 2'h0);
        test_done();
    end
endmodule : ldm_controller_tb_top
